// ---- src/fwp_pkg.sv ----
`default_nettype none
package fwp_pkg;
    // Flash command codes written on the data bus
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
    localparam logic [7:0] CMD_CHIP_SETUP   = 8'h30;
    localparam logic [7:0] CMD_WRITE_SETUP  = 8'h40;
    localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
    localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
    localparam logic [7:0] CMD_SET_BLOCK    = 8'h01;
    localparam logic [7:0] CMD_SET_PERM     = 8'hF1;
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
    // Operation status bit positions
    localparam int SR_READY     = 7;
    localparam int SR_ERASE_SUS = 6;
    localparam int SR_ERASE_ERR = 5;
    localparam int SR_WRITE_ERR = 4;
    localparam int SR_SUPPLY    = 3;
    localparam int SR_WRITE_SUS = 2;
    localparam int SR_PROTECT   = 1;
    // Polling mask: reserved bit 0 always dropped
    localparam logic [7:0] SR_POLL_MASK = 8'hFE;
    // APB register byte addresses
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_DATA   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    // Control register fields
    localparam int CTRL_START = 0;
    localparam int CTRL_OP_LO = 1;
    // Operation codes in the control register
    localparam logic [2:0] OP_ERASE   = 3'h0;
    localparam logic [2:0] OP_WRITE   = 3'h1;
    localparam logic [2:0] OP_CHIP    = 3'h2;
    localparam logic [2:0] OP_SETBLK  = 3'h3;
    localparam logic [2:0] OP_CLRBLK  = 3'h4;
    localparam logic [2:0] OP_SETPERM = 3'h5;
    localparam logic [2:0] OP_CLRSR   = 3'h6;
    // Bus strobe timing: least 100 ns low and high
    localparam int STROBE_NS  = 100;
    localparam int CLK_NS     = 50;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    // Sequencer states
    typedef enum logic [3:0] {
        FWP_IDLE, FWP_WR_LO, FWP_WR_HI, FWP_RD_LO, FWP_RD_HI, FWP_NEXT
    } fwp_state_t;
endpackage
`default_nettype wire

// ---- src/fwp_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module fwp_host
    import fwp_pkg::*;
#(
    parameter int AW = 21
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    output logic      [AW-1:0] flash_addr,
    output logic      [7:0]    flash_dq_out,
    output logic               flash_dq_oe,
    input  wire logic [7:0]    flash_dq_in,
    output logic               flash_ce_n,
    output logic               flash_we_n,
    output logic               flash_oe_n,
    input  wire logic          ready_busy_pin
);
    // Sequence steps: list of bus cycles to issue
    fwp_state_t     st_r, st_nxt;       // Sequencer state
    logic [2:0]     op_r, op_nxt;       // Operation in progress
    logic [2:0]     step_r, step_nxt;   // Step within sequence
    logic [3:0]     cnt_r, cnt_nxt;     // Strobe width counter
    logic           busy_r, busy_nxt;   // Sequence running
    logic           done_r, done_nxt;   // Sticky done flag
    logic [AW-1:0]  tadr_r, tadr_nxt;   // Target address
    logic [7:0]     tdat_r, tdat_nxt;   // Write data
    logic [7:0]     sr_r, sr_nxt;       // Last valid status, bit 0 masked
    logic [31:0]    prdata_nxt;
    logic [AW-1:0]  fa_nxt;
    logic [7:0]     fd_nxt;
    logic           oe_nxt, ce_nxt, we_nxt, rd_nxt, pready_nxt, err_nxt;

    // One bus cycle of a sequence: is it a write, and with which data
    function automatic logic step_is_write(input logic [2:0] op, input logic [2:0] s);
        // Step 0 writes read-status, 1 polls, 2 and 3 write the pair, 4 polls, 5 leaves
        if (op == OP_CLRSR)
            return (s == 3'h0) || (s == 3'h2);
        return (s == 3'h0) || (s == 3'h2) || (s == 3'h3) || (s == 3'h5);
    endfunction

    function automatic logic [7:0] step_data(input logic [2:0] op, input logic [2:0] s,
                                             input logic [7:0] d);
        step_data = CMD_READ_STATUS;
        if (s == 3'h5)
            step_data = CMD_READ_ARRAY;
        else if (op == OP_CLRSR && s == 3'h2)
            step_data = CMD_CLEAR_STATUS;
        else if (s == 3'h2) begin
            unique case (op)
                OP_ERASE:  step_data = CMD_ERASE_SETUP;
                OP_WRITE:  step_data = CMD_WRITE_SETUP;
                OP_CHIP:   step_data = CMD_CHIP_SETUP;
                OP_CLRBLK: step_data = CMD_LOCK_SETUP;
                default:   step_data = CMD_LOCK_SETUP;
            endcase
        end else if (s == 3'h3) begin
            unique case (op)
                OP_WRITE:   step_data = d;
                OP_SETBLK:  step_data = CMD_SET_BLOCK;
                OP_SETPERM: step_data = CMD_SET_PERM;
                default:    step_data = CMD_CONFIRM;
            endcase
        end
    endfunction

    // Next-state logic for the sequencer, flash pins and APB answer
    always_comb begin
        st_nxt = st_r;  op_nxt = op_r;  step_nxt = step_r;  cnt_nxt = cnt_r;
        busy_nxt = busy_r;  done_nxt = done_r;  tadr_nxt = tadr_r;  tdat_nxt = tdat_r;
        sr_nxt = sr_r;  fa_nxt = flash_addr;  fd_nxt = flash_dq_out;  oe_nxt = flash_dq_oe;
        ce_nxt = flash_ce_n;  we_nxt = flash_we_n;  rd_nxt = flash_oe_n;
        prdata_nxt = prdata;  pready_nxt = 1'b0;  err_nxt = 1'b0;
        // APB: answer in the second access cycle, one wait state after the first
        if (psel && penable && !pready) begin
            pready_nxt = 1'b1;
            unique case (paddr)
                REG_CTRL: begin
                    prdata_nxt = {29'h0, busy_r, done_r, 1'b0};
                    if (pwrite && pwdata[CTRL_START] && !busy_r) begin
                        op_nxt   = pwdata[CTRL_OP_LO +: 3];
                        busy_nxt = 1'b1;
                        done_nxt = 1'b0;
                        step_nxt = 3'h0;
                        st_nxt   = FWP_NEXT;
                    end else if (pwrite && !pwdata[CTRL_OP_LO+3])
                        done_nxt = 1'b0;
                end
                REG_ADDR: begin
                    prdata_nxt = 32'(tadr_r);
                    if (pwrite && !busy_r) tadr_nxt = pwdata[AW-1:0];
                end
                REG_DATA: begin
                    prdata_nxt = {24'h0, tdat_r};
                    if (pwrite && !busy_r) tdat_nxt = pwdata[7:0];
                end
                REG_STATUS: prdata_nxt = {24'h0, sr_r};
                default: begin
                    prdata_nxt = 32'h0;
                    err_nxt    = 1'b1;
                end
            endcase
        end
        // Flash bus sequencer
        unique case (st_r)
            FWP_IDLE: ;
            FWP_NEXT: begin
                if (step_r == 3'h6 || (op_r == OP_CLRSR && step_r == 3'h3)) begin
                    busy_nxt = 1'b0;
                    done_nxt = 1'b1;
                    st_nxt   = FWP_IDLE;
                end else begin
                    // Second cycle of the pair (confirm, code or data) goes to the block address, others to address 0
                    fa_nxt  = (step_r == 3'h3) ? tadr_r : '0;
                    cnt_nxt = 4'(STROBE_CYC);
                    ce_nxt  = 1'b0;
                    if (step_is_write(op_r, step_r)) begin
                        fd_nxt = step_data(op_r, step_r, tdat_r);
                        oe_nxt = 1'b1;
                        we_nxt = 1'b0;
                        st_nxt = FWP_WR_LO;
                    end else begin
                        oe_nxt = 1'b0;
                        rd_nxt = 1'b0;
                        st_nxt = FWP_RD_LO;
                    end
                end
            end
            FWP_WR_LO, FWP_RD_LO: begin
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r == 4'h1) begin
                    cnt_nxt = 4'(STROBE_CYC);
                    if (st_r == FWP_RD_LO) begin
                        // Sample only once the engine reports ready
                        if (flash_dq_in[SR_READY] && ready_busy_pin) begin
                            sr_nxt = flash_dq_in & SR_POLL_MASK;
                            step_nxt = step_r + 3'h1;
                        end
                        st_nxt = FWP_RD_HI;
                    end else begin
                        step_nxt = step_r + 3'h1;
                        st_nxt = FWP_WR_HI;
                    end
                    we_nxt = 1'b1;
                    rd_nxt = 1'b1;
                end
            end
            FWP_WR_HI, FWP_RD_HI: begin
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r == 4'h1) begin
                    ce_nxt = 1'b1;
                    oe_nxt = 1'b0;
                    st_nxt = FWP_NEXT;
                end
            end
            default: st_nxt = FWP_IDLE;
        endcase
    end

    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= FWP_IDLE;  op_r <= '0;  step_r <= '0;  cnt_r <= '0;
            busy_r <= 1'b0;  done_r <= 1'b0;  tadr_r <= '0;  tdat_r <= '0;
            sr_r <= 8'h80;  flash_addr <= '0;  flash_dq_out <= '0;  flash_dq_oe <= 1'b0;
            flash_ce_n <= 1'b1;  flash_we_n <= 1'b1;  flash_oe_n <= 1'b1;
            prdata <= '0;  pready <= 1'b0;  pslverr <= 1'b0;
        end else begin
            st_r <= st_nxt;  op_r <= op_nxt;  step_r <= step_nxt;  cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;  done_r <= done_nxt;  tadr_r <= tadr_nxt;
            tdat_r <= tdat_nxt;  sr_r <= sr_nxt;  flash_addr <= fa_nxt;
            flash_dq_out <= fd_nxt;  flash_dq_oe <= oe_nxt;  flash_ce_n <= ce_nxt;
            flash_we_n <= we_nxt;  flash_oe_n <= rd_nxt;
            prdata <= prdata_nxt;  pready <= pready_nxt;  pslverr <= err_nxt;
        end
    end

    // Checks on the host's own behaviour
    a_reserved_masked: assert property (@(posedge pclk) disable iff (!presetn)
        sr_r[0] == 1'b0) else $error("reserved status bit kept");
    a_sample_ready: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(sr_r) |-> sr_r[SR_READY]) else $error("status taken while busy");
    a_no_drive_read: assert property (@(posedge pclk) disable iff (!presetn)
        !flash_oe_n |-> !flash_dq_oe) else $error("bus fight on data pins");
    a_we_width: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(flash_we_n) |-> !flash_we_n [*2]) else $error("write strobe too short");
    a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready) else $error("apb answer late");
    c_start: cover property (@(posedge pclk) $rose(busy_r));
    c_done: cover property (@(posedge pclk) $fell(busy_r));
    // Step 4 only stays put in the read-high phase when the engine answered busy
    c_poll_busy: cover property (@(posedge pclk) st_r == FWP_RD_HI && step_r == 3'h4);
    c_protect: cover property (@(posedge pclk) $rose(sr_r[SR_PROTECT]));
endmodule
`default_nettype wire

// ---- verif/fwp_flash_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Behavioural flash device: command decoder, protection table, sticky status
module fwp_flash_model #(
    parameter int AW      = 21,
    parameter int BUSY_NS = 2000
) (
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    dq_wr,
    output logic      [7:0]    dq_rd,
    input  wire logic          ce_n,
    input  wire logic          we_n,
    input  wire logic          oe_n,
    output logic               ready,
    input  wire logic          wp_n,
    input  wire logic          lockout,
    input  wire logic          rp_n
);
    logic [7:0] sr       = 8'h80; // Status, ready after power-up
    logic [7:0] setup    = 8'hFF; // Pending setup code
    logic [7:0] blk_lock = 8'h00; // One lock per block
    logic       perm     = 1'b0;  // Permanent lock
    logic [2:0] blk;              // Target block index
    logic       es;               // Error goes to bit 5, else bit 4
    logic       pr;               // Operation blocked by a lock
    logic       bad;              // Improper confirm code
    logic [7:0] rd_val;           // Value shown while the host reads
    logic [7:0] last_cmd = 8'h00; // Last byte strobed in, watched by the bench
    initial ready = 1'b1;
    assign blk = addr[AW-1:AW-3];
    // Low bits are junk while busy and the reserved bit reads 1, so the host must
    // wait for bit 7 and mask bit 0; a released bus shows the inverse, never a stale value
    assign rd_val = sr[7] ? (sr | 8'h01) : 8'h55;
    assign dq_rd = (!ce_n && !oe_n) ? rd_val : ~rd_val;
    // Commands latch on the rising write strobe
    always @(posedge we_n) begin
        if (!ce_n) last_cmd = dq_wr;
        if (!ce_n && setup != 8'hFF) begin
            es = setup == 8'h20 || setup == 8'h30 || (setup == 8'h60 && dq_wr == 8'hD0);
            bad = setup != 8'h40 && !(dq_wr == 8'hD0
                  || (setup == 8'h60 && dq_wr inside {8'h01, 8'hF1}));
            // Boot blocks sit at the top; chip erase skips guarded blocks without error
            pr = (setup == 8'h20 || setup == 8'h40)
               ? (blk_lock[blk] | (blk >= 6 && !wp_n))
               : (setup == 8'h60 && dq_wr != 8'hF1) ? perm : 1'b0;
            if (bad) begin
                sr[5:4] = 2'b11;
            end else if (lockout) begin
                sr = sr | (es ? 8'h28 : 8'h18);
            end else if (!rp_n || pr) begin
                sr = sr | (es ? 8'h22 : 8'h12);
            end else if (setup == 8'h60) begin
                if (dq_wr == 8'h01) blk_lock[blk] = 1'b1;
                if (dq_wr == 8'hD0) blk_lock = 8'h00;
                if (dq_wr == 8'hF1) perm = 1'b1;
            end
            setup = 8'hFF;
            ready = 1'b0;
            sr[7] = 1'b0;
            #BUSY_NS;
            sr[7] = 1'b1; // Suspend is never used, so bits 6 and 2 stay 0
            ready = 1'b1;
        end else if (!ce_n) begin
            if (dq_wr == 8'h50) sr[5:1] = 5'h00;
            if (dq_wr inside {8'h20, 8'h30, 8'h40, 8'h60}) setup = dq_wr;
        end
    end
endmodule
`default_nettype wire

// ---- verif/flash_write_protect_status_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module flash_write_protect_status_tb;
    import fwp_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr  = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, dq_oe, ce_n, we_n, oe_n, rdy;
    logic [20:0] faddr;
    logic [7:0]  dq_out, dev_q, dq_bus;
    logic        wp_n = 1, lockout = 0, rp_n = 1; // Device pin levels
    logic [7:0]  sh_lock = 8'h00;                  // Expected block locks
    logic        sh_perm = 0;
    int          failures = 0, n_tests = 0;
    // Wire level seen by both ends
    assign dq_bus = dq_oe ? dq_out : dev_q;
    fwp_host #(.AW(21)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_addr(faddr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
        .flash_dq_in(dq_bus), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
        .ready_busy_pin(rdy));
    fwp_flash_model #(.AW(21)) u_flash (.addr(faddr), .dq_wr(dq_bus), .dq_rd(dev_q),
        .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .ready(rdy), .wp_n(wp_n), .lockout(lockout),
        .rp_n(rp_n));
    initial forever #25 pclk = ~pclk;
    initial begin
        #3000000;
        failures++;
        stop_test();
    end
    task automatic stop_test();
        if (failures == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer; entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        r = prdata; e = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    // Start one operation and poll until it is done and idle
    task automatic run(input logic [2:0] op, input logic [2:0] b);
        logic [31:0] r;
        logic        e;
        int          n;
        n = 0;
        apb(1, REG_ADDR, {11'h0, b, 18'h0}, r, e);
        apb(1, REG_DATA, 32'h000000A5, r, e);
        apb(1, REG_CTRL, {28'h0, op, 1'b1}, r, e);
        r = 32'h0;
        while (!(r[1] === 1'b1 && r[2] === 1'b0) && n < 400) begin
            apb(0, REG_CTRL, 32'h0, r, e);
            n++;
        end
        if (n >= 400) failures++;
    endtask
    // Expected status from the protection table, updating the lock shadow
    function automatic logic [7:0] expect_sr(input logic [2:0] op, input logic [2:0] b);
        logic es, pr;
        es = op == OP_ERASE || op == OP_CHIP || op == OP_CLRBLK;
        pr = (op == OP_ERASE || op == OP_WRITE) ? (sh_lock[b] | (b >= 6 && !wp_n))
           : (op == OP_SETBLK || op == OP_CLRBLK) ? sh_perm : 1'b0;
        if (lockout) return es ? 8'hA8 : 8'h98;
        if (!rp_n || pr) return es ? 8'hA2 : 8'h92;
        if (op == OP_SETBLK) sh_lock[b] = 1'b1;
        if (op == OP_CLRBLK) sh_lock = 8'h00;
        if (op == OP_SETPERM) sh_perm = 1'b1;
        return 8'h80;
    endfunction
    // Clear status, run one operation, compare the reported status
    task automatic tst(input logic [2:0] op, input logic [2:0] b);
        logic [31:0] r;
        logic        e;
        logic [7:0]  x;
        run(OP_CLRSR, 3'h0);
        x = expect_sr(op, b);
        run(op, b);
        chk("read array", {24'h0, u_flash.last_cmd}, {24'h0, CMD_READ_ARRAY});
        apb(0, REG_STATUS, 32'h0, r, e);
        chk("status", r, {24'h0, x});
    endtask
    initial begin
        logic [31:0] r;
        logic        e;
        r = $urandom(32'hAC4F2E5B);
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, REG_STATUS, 32'h0, r, e);
        chk("reset status", r, 32'h00000080);
        apb(0, 8'h10, 32'h0, r, e);
        chk("unmapped err", {31'h0, e}, 32'h1);
        chk("unmapped data", r, 32'h0);
        wp_n = 0;
        tst(OP_ERASE, 3'h7);
        tst(OP_WRITE, 3'h6);
        tst(OP_WRITE, 3'h0);
        wp_n = 1;
        tst(OP_ERASE, 3'h7);
        tst(OP_SETBLK, 3'h3);
        tst(OP_WRITE, 3'h3);
        wp_n = 0;
        tst(OP_ERASE, 3'h3);
        tst(OP_CHIP, 3'h0);
        tst(OP_CLRBLK, 3'h0);
        lockout = 1;
        for (int i = 0; i < 6; i++) tst(i[2:0], 3'h1);
        lockout = 0;
        rp_n = 0;
        tst(OP_SETPERM, 3'h0);
        rp_n = 1;
        tst(OP_ERASE, 3'h6);
        run(OP_ERASE, 3'h0);
        apb(0, REG_STATUS, 32'h0, r, e);
        chk("sticky", r, 32'h000000A2);
        // The target address must not move under a running sequence
        apb(1, REG_ADDR, 32'h00080000, r, e);
        apb(1, REG_CTRL, {28'h0, OP_CLRSR, 1'b1}, r, e);
        apb(1, REG_ADDR, 32'h001C0000, r, e);
        apb(0, REG_ADDR, 32'h0, r, e);
        chk("addr held", r, 32'h00080000);
        repeat (80) @(posedge pclk);
        for (int i = 0; i < 24; i++) begin
            wp_n = 1'($urandom);
            lockout = ($urandom % 8) == 0;
            tst(3'($urandom % 5), 3'($urandom));
        end
        lockout = 0;
        tst(OP_SETPERM, 3'h0);
        tst(OP_SETBLK, 3'h1);
        tst(OP_CLRBLK, 3'h0);
        tst(OP_SETPERM, 3'h0);
        stop_test();
    end
endmodule
`default_nettype wire
